// File: rtl/mps_consts.vh
// Constants for the module power-state sequencer
`ifndef MPS_CONSTS_VH
`define MPS_CONSTS_VH
`define MPS_LPS_WAKE_PINS   3'h5
`define MPS_USB_WAKE_ON     2'h0
`define MPS_FUN_FAST_OFF    5'h0A
`define MPS_FUN_SAFE_OFF    5'h0B
`define MPS_FUN_REBOOT      5'h10
`define MPS_PINFN_WAKE      2'h1
`define MPS_PINFN_FAST_OFF  2'h2
`define MPS_PINFN_SAFE_OFF  2'h3
`define MPS_QUAL_ON         32'd1000
`define MPS_QUAL_WAKE       32'd100
`define MPS_QUAL_OFF        32'd2000
`define MPS_QUAL_RST        32'd1000
`define MPS_SUPPLY_QUAL     32'd16
`define MPS_SEQ_CYCLES      32'd8
`endif

// File: rtl/mps_sync.v
// Two-flop synchroniser with rising edge detect on the settled copy
`timescale 1ns/1ps
module mps_sync #(
  parameter RESET_VAL = 1'b1
) (
  input  wire i_ref_clk,
  input  wire i_reset_n,
  input  wire i_async,
  output wire o_level,
  output wire o_rise
);
  reg meta;
  reg sync;
  reg prev;
  always @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      meta <= RESET_VAL;
      sync <= RESET_VAL;
      prev <= RESET_VAL;
    end else begin
      meta <= i_async;
      sync <= meta;
      prev <= sync;
    end
  end
  assign o_level = sync;
  assign o_rise  = sync & ~prev;
endmodule // mps_sync

// File: rtl/mps_lowqual.v
// Counts how long an input stays low; pulses once when the count is reached
`timescale 1ns/1ps
module mps_lowqual #(
  parameter CW = 16
) (
  input  wire          i_ref_clk,
  input  wire          i_reset_n,
  input  wire          i_low,
  input  wire [CW-1:0] i_limit,
  output wire          o_hit,
  output wire          o_held
);
  reg [CW-1:0] cnt;
  reg          done;
  wire         reach = i_low && !done && (cnt >= i_limit - 1'b1);
  always @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      cnt  <= {CW{1'b0}};
      done <= 1'b0;
    end else if (!i_low) begin
      cnt  <= {CW{1'b0}};
      done <= 1'b0;
    end else if (reach) begin
      done <= 1'b1;
    end else if (!done) begin
      cnt <= cnt + 1'b1;
    end
  end
  assign o_hit  = reach;
  assign o_held = done;
endmodule // mps_lowqual

// File: rtl/mps_sequencer.v
// Power-state sequencer: switch-on, deep-sleep wake, switch-off grades and resets
// Summary of operation
// - From unpowered, switch on when supply good and key held low long enough.
// - From power-off with supply, switch on on qualified key-low.
// - Key input reads high when undriven, via internal pull-up.
// - In deep-sleep, qualified key-low for wake period wakes the device.
// - Low power setting 5 lets wake pin rising edges wake deep-sleep.
// - USB sleep setting 0 lets a USB resume wake deep-sleep.
// - Key tied low switches on one on-qualification period after supply is qualified.
// - Key tied low: graceful off, then only restart pin switches on.
// - Key tied low: deep-sleep wakes only by wake pins or USB resume.
// - Graceful off saves settings, detaches; by command or long key-low.
// - Fast emergency off saves settings only; command 10 or configured pin edge.
// - Memory-safe off blocks flash; command 11 or configured pin edge.
// - Supply loss gives abrupt shutdown, no save, no detach.
// - Function command 16 saves, detaches, then reboots.
// - Qualified restart pin low restarts power unit from on or deep-sleep, no save, no detach; from power-off it switches on directly.
// - Interface rail on only while switched on and awake, and through the save and detach steps.
`timescale 1ns/1ps
`include "mps_consts.vh"
module mps_sequencer #(
  parameter CW          = 16,
  parameter QUAL_ON     = `MPS_QUAL_ON,
  parameter QUAL_WAKE   = `MPS_QUAL_WAKE,
  parameter QUAL_OFF    = `MPS_QUAL_OFF,
  parameter QUAL_RST    = `MPS_QUAL_RST,
  parameter SUPPLY_QUAL = `MPS_SUPPLY_QUAL,
  parameter SEQ_CYCLES  = `MPS_SEQ_CYCLES
) (
  input  wire       i_ref_clk,
  input  wire       i_reset_n,
  input  wire       i_supply_good,
  input  wire       i_power_key_pin,
  input  wire       i_restart_pin_n,
  input  wire       i_wake_pin_a,
  input  wire       i_wake_pin_b,
  input  wire       i_usb_resume,
  input  wire [2:0] i_low_power_setting,
  input  wire [1:0] i_usb_sleep_setting,
  input  wire [1:0] i_wake_pin_a_func,
  input  wire [1:0] i_wake_pin_b_func,
  input  wire       i_sleep_req,
  input  wire       i_graceful_off_cmd,
  input  wire       i_function_level_cmd,
  input  wire [4:0] i_function_level,
  output reg        o_unpowered,
  output reg        o_power_off,
  output reg        o_on,
  output reg        o_deep_sleep,
  output reg        o_busy,
  output reg        o_iface_rail_en,
  output reg        o_save_settings,
  output reg        o_net_detach,
  output reg        o_flash_block,
  output reg        o_pmu_restart,
  output reg        o_key_pullup_en
);
  ////////////////////////////////////////////////////////////////////////////
  localparam [6:0] ST_UNPWR = 7'h01;
  localparam [6:0] ST_OFF   = 7'h02;
  localparam [6:0] ST_ON    = 7'h04;
  localparam [6:0] ST_SLEEP = 7'h08;
  localparam [6:0] ST_SAVE  = 7'h10;
  localparam [6:0] ST_DTCH  = 7'h20;
  localparam [6:0] ST_RBOOT = 7'h40;

  localparam [CW-1:0] LIM_ON    = QUAL_ON[CW-1:0];
  localparam [CW-1:0] LIM_WAKE  = QUAL_WAKE[CW-1:0];
  localparam [CW-1:0] LIM_OFF   = QUAL_OFF[CW-1:0];
  localparam [CW-1:0] LIM_RST   = QUAL_RST[CW-1:0];
  localparam [CW-1:0] LIM_SUP   = SUPPLY_QUAL[CW-1:0];
  localparam [CW-1:0] LIM_SEQ   = SEQ_CYCLES[CW-1:0];

  ////////////////////////////////////////////////////////////////////////////
  // Every pin crosses in through two flops before any decision
  wire key_lvl, rst_lvl, sup_lvl;
  wire a_rise, b_rise, usb_rise;
  mps_sync #(.RESET_VAL(1'b1)) u_key (
    .i_ref_clk (i_ref_clk),
    .i_reset_n (i_reset_n),
    .i_async   (i_power_key_pin),
    .o_level   (key_lvl),
    .o_rise    ()
  );
  mps_sync #(.RESET_VAL(1'b1)) u_rst (
    .i_ref_clk (i_ref_clk),
    .i_reset_n (i_reset_n),
    .i_async   (i_restart_pin_n),
    .o_level   (rst_lvl),
    .o_rise    ()
  );
  mps_sync #(.RESET_VAL(1'b0)) u_sup (
    .i_ref_clk (i_ref_clk),
    .i_reset_n (i_reset_n),
    .i_async   (i_supply_good),
    .o_level   (sup_lvl),
    .o_rise    ()
  );
  mps_sync #(.RESET_VAL(1'b0)) u_usb (
    .i_ref_clk (i_ref_clk),
    .i_reset_n (i_reset_n),
    .i_async   (i_usb_resume),
    .o_level   (),
    .o_rise    (usb_rise)
  );
  mps_sync #(.RESET_VAL(1'b0)) u_wa (
    .i_ref_clk (i_ref_clk),
    .i_reset_n (i_reset_n),
    .i_async   (i_wake_pin_a),
    .o_level   (),
    .o_rise    (a_rise)
  );
  mps_sync #(.RESET_VAL(1'b0)) u_wb (
    .i_ref_clk (i_ref_clk),
    .i_reset_n (i_reset_n),
    .i_async   (i_wake_pin_b),
    .o_level   (),
    .o_rise    (b_rise)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Low-level qualifiers; supply qualifier needs supply good for SUPPLY_QUAL cycles and drops at once on any dip
  wire on_hit, wake_hit, off_hit, rst_hit, sup_ok, key_held;
  mps_lowqual #(.CW(CW)) u_q_on (
    .i_ref_clk (i_ref_clk),
    .i_reset_n (i_reset_n),
    .i_low     (~key_lvl & sup_ok),
    .i_limit   (LIM_ON),
    .o_hit     (on_hit),
    .o_held    (key_held)
  );
  mps_lowqual #(.CW(CW)) u_q_wk (
    .i_ref_clk (i_ref_clk),
    .i_reset_n (i_reset_n),
    .i_low     (~key_lvl),
    .i_limit   (LIM_WAKE),
    .o_hit     (wake_hit),
    .o_held    ()
  );
  mps_lowqual #(.CW(CW)) u_q_of (
    .i_ref_clk (i_ref_clk),
    .i_reset_n (i_reset_n),
    .i_low     (~key_lvl),
    .i_limit   (LIM_OFF),
    .o_hit     (off_hit),
    .o_held    ()
  );
  mps_lowqual #(.CW(CW)) u_q_rs (
    .i_ref_clk (i_ref_clk),
    .i_reset_n (i_reset_n),
    .i_low     (~rst_lvl),
    .i_limit   (LIM_RST),
    .o_hit     (rst_hit),
    .o_held    ()
  );
  mps_lowqual #(.CW(CW)) u_q_sp (
    .i_ref_clk (i_ref_clk),
    .i_reset_n (i_reset_n),
    .i_low     (sup_lvl),
    .i_limit   (LIM_SUP),
    .o_hit     (),
    .o_held    (sup_ok)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Wake pin events decoded by the configured function of each pin
  wire pin_wake = (a_rise && i_wake_pin_a_func == `MPS_PINFN_WAKE) ||
                  (b_rise && i_wake_pin_b_func == `MPS_PINFN_WAKE);
  wire pin_fast = (a_rise && i_wake_pin_a_func == `MPS_PINFN_FAST_OFF) ||
                  (b_rise && i_wake_pin_b_func == `MPS_PINFN_FAST_OFF);
  wire pin_safe = (a_rise && i_wake_pin_a_func == `MPS_PINFN_SAFE_OFF) ||
                  (b_rise && i_wake_pin_b_func == `MPS_PINFN_SAFE_OFF);
  wire wake_by_pin = pin_wake && (i_low_power_setting == `MPS_LPS_WAKE_PINS);
  wire wake_by_usb = usb_rise && (i_usb_sleep_setting == `MPS_USB_WAKE_ON);
  wire cmd_fast   = i_function_level_cmd && i_function_level == `MPS_FUN_FAST_OFF;
  wire cmd_safe   = i_function_level_cmd && i_function_level == `MPS_FUN_SAFE_OFF;
  wire cmd_reboot = i_function_level_cmd && i_function_level == `MPS_FUN_REBOOT;

  ////////////////////////////////////////////////////////////////////////////
  reg [6:0]    state;
  reg [6:0]    next_state;
  reg [CW-1:0] seq_cnt;
  reg          do_detach;
  reg          do_reboot;
  reg          next_do_detach;
  reg          next_do_reboot;
  reg          tied_arm;
  wire         seq_done = (seq_cnt >= LIM_SEQ - 1'b1);

  always @* begin
    next_state     = state;
    next_do_detach = do_detach;
    next_do_reboot = do_reboot;
    case (state)
      ST_UNPWR: begin
        // A key already held low is counted only once supply is qualified, so a tied pin powers up one on period later
        if (on_hit) begin
          next_state = ST_ON;
        end
      end
      ST_OFF: begin
        // A key that was low before entering off must be released first
        if (rst_hit) begin
          next_state = ST_ON;
        end else if (on_hit) begin
          next_state = ST_ON;
        end
      end
      ST_ON: begin
        if (rst_hit) begin
          next_state = ST_RBOOT;
        end else if (cmd_safe || pin_safe) begin
          next_state = ST_OFF;
        end else if (i_graceful_off_cmd || (off_hit && !tied_arm)) begin
          next_state     = ST_SAVE;
          next_do_detach = 1'b1;
          next_do_reboot = 1'b0;
        end else if (cmd_reboot) begin
          next_state     = ST_SAVE;
          next_do_detach = 1'b1;
          next_do_reboot = 1'b1;
        end else if (cmd_fast || pin_fast) begin
          next_state     = ST_SAVE;
          next_do_detach = 1'b0;
          next_do_reboot = 1'b0;
        end else if (i_sleep_req) begin
          next_state = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (rst_hit) begin
          next_state = ST_RBOOT;
        end else if ((wake_hit && !tied_arm) || wake_by_pin || wake_by_usb) begin
          next_state = ST_ON;
        end
      end
      ST_SAVE: begin
        if (seq_done) begin
          next_state = do_detach ? ST_DTCH : ST_OFF;
        end
      end
      ST_DTCH: begin
        if (seq_done) begin
          next_state = do_reboot ? ST_RBOOT : ST_OFF;
        end
      end
      ST_RBOOT: begin
        if (seq_done && rst_lvl) begin
          next_state = ST_ON;
        end
      end
      default: begin
        next_state = ST_UNPWR;
      end
    endcase
    if (!sup_ok) begin
      next_state = ST_UNPWR;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      state     <= ST_UNPWR;
      seq_cnt   <= {CW{1'b0}};
      do_detach <= 1'b0;
      do_reboot <= 1'b0;
      tied_arm  <= 1'b0;
    end else begin
      state     <= next_state;
      do_detach <= next_do_detach;
      do_reboot <= next_do_reboot;
      if (next_state != state) begin
        seq_cnt <= {CW{1'b0}};
      end else if (!seq_done) begin
        seq_cnt <= seq_cnt + 1'b1;
      end
      // A key held from switch-on is treated as tied: it neither switches off nor wakes
      if (key_lvl) begin
        tied_arm <= 1'b0;
      end else if (next_state == ST_ON && state != ST_ON && (on_hit || key_held)) begin
        tied_arm <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      o_unpowered     <= 1'b1;
      o_power_off     <= 1'b0;
      o_on            <= 1'b0;
      o_deep_sleep    <= 1'b0;
      o_busy          <= 1'b0;
      o_iface_rail_en <= 1'b0;
      o_save_settings <= 1'b0;
      o_net_detach    <= 1'b0;
      o_flash_block   <= 1'b0;
      o_pmu_restart   <= 1'b0;
      o_key_pullup_en <= 1'b1;
    end else begin
      o_unpowered     <= next_state == ST_UNPWR;
      o_power_off     <= next_state == ST_OFF;
      o_on            <= next_state == ST_ON;
      o_deep_sleep    <= next_state == ST_SLEEP;
      o_busy          <= (next_state == ST_SAVE) || (next_state == ST_DTCH) || (next_state == ST_RBOOT);
      o_iface_rail_en <= (next_state == ST_ON) || (next_state == ST_SAVE) || (next_state == ST_DTCH);
      o_save_settings <= next_state == ST_SAVE;
      o_net_detach    <= next_state == ST_DTCH;
      if (next_state == ST_ON) begin
        o_flash_block <= 1'b0;
      end else if (state == ST_ON && (cmd_safe || pin_safe)) begin
        o_flash_block <= 1'b1;
      end
      o_pmu_restart   <= next_state == ST_RBOOT;
      o_key_pullup_en <= 1'b1;
    end
  end
endmodule // mps_sequencer

// File: tb/mps_seq_props.sv
// Concurrent checks on the power-state sequencer ports
`timescale 1ns/1ps
module mps_seq_props #(
  parameter SEQ_CYCLES = 8
) (
  input wire       i_ref_clk,
  input wire       i_reset_n,
  input wire       i_supply_good,
  input wire       i_restart_pin_n,
  input wire       i_graceful_off_cmd,
  input wire       i_function_level_cmd,
  input wire [4:0] i_function_level,
  input wire       o_unpowered,
  input wire       o_power_off,
  input wire       o_on,
  input wire       o_deep_sleep,
  input wire       o_busy,
  input wire       o_iface_rail_en,
  input wire       o_save_settings,
  input wire       o_net_detach,
  input wire       o_flash_block,
  input wire       o_pmu_restart,
  input wire       o_key_pullup_en
);
  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);
  // Commands count only in a settled on state with no restart competing
  wire cmd_ok = o_on && !o_busy && i_restart_pin_n;
  wire fn_ok  = cmd_ok && i_function_level_cmd && !i_graceful_off_cmd;
  // Repeat fixed at 8 since counts cannot be parameters here; bench keeps SEQ_CYCLES at 8
  sequence save_run; o_save_settings [*8]; endsequence
  sequence detach_step; !o_save_settings && o_net_detach; endsequence
  ////////////////////////////////////////////////////////////////////////
  rail_gate_a: assert property (o_iface_rail_en |-> (o_on || o_busy) && !o_pmu_restart && !o_deep_sleep)
    else $error("rail enabled outside on");
  one_state_a: assert property ($onehot0({o_unpowered, o_power_off, o_on, o_deep_sleep}))
    else $error("two states at once");
  key_pullup_a: assert property (o_key_pullup_en)
    else $error("key pull-up off");
  reboot_seq_a: assert property (fn_ok && i_function_level == 5'h10 |=> save_run ##1 detach_step)
    else $error("reboot save or detach wrong");
  fast_off_a: assert property (fn_ok && i_function_level == 5'h0A |=> save_run ##1 !o_net_detach ##[0:2] o_power_off)
    else $error("fast off sequence wrong");
  safe_off_a: assert property (fn_ok && i_function_level == 5'h0B |=> o_power_off && o_flash_block && !o_save_settings)
    else $error("memory-safe off wrong");
  graceful_seq_a: assert property (cmd_ok && i_graceful_off_cmd |=> save_run ##1 detach_step)
    else $error("graceful off sequence wrong");
  restart_clean_a: assert property (o_pmu_restart |-> !o_save_settings && !o_net_detach)
    else $error("restart with save or detach");
  supply_loss_a: assert property ($fell(i_supply_good) ##1 !i_supply_good [*6] |-> o_unpowered && !o_busy)
    else $error("no shutdown on supply loss");
endmodule // mps_seq_props
bind mps_sequencer mps_seq_props #(.SEQ_CYCLES(SEQ_CYCLES)) u_mps_seq_props (.*);

// File: tb/mps_pin_drv.sv
// Push-pull switch drivers on the key and restart pins: low when pulled, driven high when released
`timescale 1ns/1ps
module mps_pin_drv (
  input  wire i_key_pull,
  input  wire i_rst_pull,
  output wire o_key_pin,
  output wire o_restart_pin_n
);
  // Pins are pulled low when asserted; a released line is driven to 1 in place of the pull-up level
  assign o_key_pin       = i_key_pull ? 1'b0 : 1'b1;
  assign o_restart_pin_n = i_rst_pull ? 1'b0 : 1'b1;
endmodule // mps_pin_drv

// File: tb/testbench.sv
// Self-checking bench for the power-state sequencer
`timescale 1ns/1ps
module testbench;
  localparam UNP = 0, OFF = 1, ON = 2, SLP = 3;
  reg        ref_clk = 1'b0;
  reg        reset_n, supply, key_pull, rst_pull, wa, wb, usb, sleep_req, goff, fcmd;
  reg  [2:0] lps;
  reg  [1:0] uss, fa, fb;
  reg  [4:0] flv, v;
  reg [31:0] lfsr = 32'h9243;
  wire       key_pin, rst_pin_n, o_busy, o_save, o_det, o_fb, o_pmu, o_pu;
  wire [4:0] st;
  integer    mismatches = 0, check_count = 0, cycles = 0, i;
  ////////////////////////////////////////////////////////////////////////
  mps_sequencer #(.QUAL_ON(4), .QUAL_WAKE(4), .QUAL_OFF(8), .QUAL_RST(4), .SUPPLY_QUAL(4)) u_mps_sequencer (
    .i_ref_clk(ref_clk), .i_reset_n(reset_n), .i_supply_good(supply), .i_power_key_pin(key_pin),
    .i_restart_pin_n(rst_pin_n), .i_wake_pin_a(wa), .i_wake_pin_b(wb), .i_usb_resume(usb),
    .i_low_power_setting(lps), .i_usb_sleep_setting(uss), .i_wake_pin_a_func(fa), .i_wake_pin_b_func(fb),
    .i_sleep_req(sleep_req), .i_graceful_off_cmd(goff), .i_function_level_cmd(fcmd), .i_function_level(flv),
    .o_unpowered(st[4]), .o_power_off(st[3]), .o_on(st[2]), .o_deep_sleep(st[1]), .o_busy(o_busy),
    .o_iface_rail_en(st[0]), .o_save_settings(o_save), .o_net_detach(o_det), .o_flash_block(o_fb),
    .o_pmu_restart(o_pmu), .o_key_pullup_en(o_pu));
  mps_pin_drv u_mps_pin_drv (.i_key_pull(key_pull), .i_rst_pull(rst_pull), .o_key_pin(key_pin),
    .o_restart_pin_n(rst_pin_n));
  always #4 ref_clk = ~ref_clk;
  ////////////////////////////////////////////////////////////////////////
  function [31:0] nxt(input [31:0] x);
    nxt = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // Expected state vector: one-hot state plus rail, rail only when on
  function [4:0] stv(input integer s);
    stv = {s == UNP, s == OFF, s == ON, s == SLP, s == ON};
  endfunction
  task cyc(input integer n);
    begin
      repeat (n) @(posedge ref_clk);
      #1;
    end
  endtask
  task chk(input [8*6-1:0] nm, input [4:0] exp, input [4:0] got);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("[ERR] %0s exp %b got %b", nm, exp, got);
      end
    end
  endtask
  // Bounded wait for the model state, then compare
  task go(input integer s);
    begin
      for (i = 0; i < 300 && st !== stv(s); i = i + 1) cyc(1);
      chk("state", stv(s), st);
    end
  endtask
  task nap;
    begin
      sleep_req = 1'b1;
      go(SLP);
      sleep_req = 1'b0;
    end
  endtask
  task key_on;
    begin
      key_pull = 1'b1;
      go(ON);
      key_pull = 1'b0;
      cyc(4);
    end
  endtask
  task rise(input integer p);
    begin
      if (p == 0) wa = 1'b1;
      else if (p == 1) wb = 1'b1;
      else usb = 1'b1;
      cyc(6);
      {wa, wb, usb} = 3'b0;
      cyc(2);
    end
  endtask
  task fn(input [4:0] lv);
    begin
      flv = lv;
      fcmd = 1'b1;
      cyc(1);
      fcmd = 1'b0;
      cyc(2);
    end
  endtask
  task summarize;
    begin
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  // Ceiling well above the roughly 500 cycles the sequence needs
  always @(posedge ref_clk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      mismatches = mismatches + 1;
      summarize;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {reset_n, supply, key_pull, rst_pull, wa, wb, usb, sleep_req, goff, fcmd} = 10'h000;
    {lps, fa, fb, flv} = 12'h000;
    uss = 2'h1;
    cyc(4);
    reset_n = 1'b1;
    go(UNP);
    chk("pullup", 5'h01, {4'h0, o_pu});
    supply = 1'b1;
    cyc(30);
    chk("state", stv(UNP), st);
    key_on;
    nap;
    key_on;
    nap;
    rise(0);
    // USB resume and a wake-configured pin are both gated by their settings here
    rise(2);
    fa = 2'h1;
    rise(0);
    cyc(20);
    chk("state", stv(SLP), st);
    key_on;
    lps = 3'h5;
    fb = 2'h1;
    nap;
    rise(0);
    go(ON);
    nap;
    rise(1);
    go(ON);
    rise(0);
    cyc(20);
    chk("state", stv(ON), st);
    uss = 2'h0;
    nap;
    rise(2);
    go(ON);
    for (i = 0; i < 4; i = i + 1) begin
      lfsr = nxt(lfsr);
      v = (lfsr[4:0] == 5'h0A || lfsr[4:0] == 5'h0B || lfsr[4:0] == 5'h10) ? 5'h01 : lfsr[4:0];
      fn(v);
      chk("state", stv(ON), st);
    end
    fn(5'h10);
    chk("seqout", 5'h06, {2'h0, o_busy, o_save, o_det});
    cyc(8);
    chk("seqout", 5'h05, {2'h0, o_busy, o_save, o_det});
    go(ON);
    fn(5'h0A);
    go(OFF);
    key_on;
    fn(5'h0B);
    go(OFF);
    chk("flash", 5'h01, {4'h0, o_fb});
    key_on;
    chk("flash", 5'h00, {4'h0, o_fb});
    goff = 1'b1;
    cyc(1);
    goff = 1'b0;
    go(OFF);
    key_on;
    key_pull = 1'b1;
    go(OFF);
    key_pull = 1'b0;
    cyc(4);
    key_on;
    fb = 2'h2;
    rise(1);
    go(OFF);
    key_on;
    fb = 2'h3;
    rise(1);
    go(OFF);
    key_on;
    rst_pull = 1'b1;
    for (i = 0; i < 50 && o_pmu !== 1'b1; i = i + 1) cyc(1);
    chk("pmu", 5'h01, {4'h0, o_pmu});
    rst_pull = 1'b0;
    go(ON);
    supply = 1'b0;
    go(UNP);
    key_pull = 1'b1;
    supply = 1'b1;
    go(ON);
    goff = 1'b1;
    cyc(1);
    goff = 1'b0;
    go(OFF);
    cyc(30);
    chk("state", stv(OFF), st);
    rst_pull = 1'b1;
    cyc(14);
    rst_pull = 1'b0;
    go(ON);
    nap;
    cyc(30);
    chk("state", stv(SLP), st);
    rise(2);
    go(ON);
    summarize;
  end
endmodule // testbench
